// ===== common/csir_defines.vh
`ifndef CSIR_DEFINES_VH
`define CSIR_DEFINES_VH

// slave addresses
`define CSIR_ACC_SLAVE_ADDR      7'h18
`define CSIR_MAG_SLAVE_ADDR      7'h1E

// accelerometer register offsets
`define CSIR_ACC_CTRL_ONE        8'h20
`define CSIR_ACC_CTRL_FOUR       8'h23
`define CSIR_ACC_X_LOWER         8'h28
`define CSIR_ACC_X_UPPER         8'h29
`define CSIR_ACC_Y_LOWER         8'h2A
`define CSIR_ACC_Y_UPPER         8'h2B
`define CSIR_ACC_Z_LOWER         8'h2C
`define CSIR_ACC_Z_UPPER         8'h2D

// magnetometer register offsets
`define CSIR_MAG_CONFIG_A        8'h00
`define CSIR_MAG_CONFIG_B        8'h01
`define CSIR_MAG_OPER_MODE       8'h02
`define CSIR_MAG_X_HIGH          8'h03
`define CSIR_MAG_X_LOW           8'h04
`define CSIR_MAG_Y_HIGH          8'h05
`define CSIR_MAG_Y_LOW           8'h06
`define CSIR_MAG_Z_HIGH          8'h07
`define CSIR_MAG_Z_LOW           8'h08

// reset values
`define CSIR_ACC_CTRL_ONE_RST    8'h07
`define CSIR_ACC_CTRL_FOUR_RST   8'h00
`define CSIR_MAG_CONFIG_A_RST    8'h10
`define CSIR_MAG_CONFIG_B_RST    8'h20
`define CSIR_MAG_OPER_MODE_RST   8'h03

// field positions and the continuous mode value
`define CSIR_ACC_POWER_HI        7
`define CSIR_ACC_POWER_LO        5
`define CSIR_ACC_ENDIAN_BIT      6
`define CSIR_MAG_RATE_HI         4
`define CSIR_MAG_RATE_LO         2
`define CSIR_MAG_MODE_HI         1
`define CSIR_MAG_MODE_LO         0
`define CSIR_MAG_MODE_CONT       2'h0

`endif

// ===== rtl/csir_top.v
// How it works
// - the accelerometer answers at 7-bit address 0011000 when the select pin is low.
// - the magnetometer answers as its own slave at fixed 7-bit address 0011110.
// - writing 0x27 to accelerometer control one at 20h gives normal mode at 50 Hz.
// - writing 0x40 to accelerometer control four at 23h gives smallest range, continuous update, big-endian.
// - accelerometer data sits at 28h..2Dh in X, Y, Z pairs, high byte at the lower address when big-endian.
// - magnetometer rate is 15 Hz after power-on and 30 Hz after 0x14 is written to config A at 00h.
// - magnetometer starts asleep and writing 0x00 to the mode register at 02h makes it convert continuously.
// - the magnetometer pointer advances by one after every read, so 02h is followed by 03h.
// - magnetometer data runs X high, X low, Y high, Y low, Z high, Z low.
`timescale 1ns/1ns
`include "csir_defines.vh"

module csir_top
#(
    parameter BUF_WIDTH = 96,
    parameter BUF_DEPTH = 2,
    parameter BUF_AW    = 1
)
(
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_scl,
    input  wire        i_sda,
    output wire        o_sda_out,
    output wire        o_sda_oe_n,
    input  wire        i_accel_address_select_pin,
    input  wire        i_sample_valid,
    output wire        o_sample_ready,
    input  wire [15:0] i_acc_x,
    input  wire [15:0] i_acc_y,
    input  wire [15:0] i_acc_z,
    input  wire [15:0] i_mag_x,
    input  wire [15:0] i_mag_y,
    input  wire [15:0] i_mag_z,
    output wire        o_accel_normal_mode,
    output wire        o_accel_big_endian,
    output wire [2:0]  o_mag_output_data_rate,
    output wire        o_mag_continuous
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_AACK = 3'h2;
    localparam [2:0] ST_RXB  = 3'h3;
    localparam [2:0] ST_RACK = 3'h4;
    localparam [2:0] ST_TXB  = 3'h5;
    localparam [2:0] ST_MACK = 3'h6;

    // three-stage synchronisers for scl, sda, select pin
    wire [2:0] pin_in;
    wire [2:0] pin_s2;
    wire [2:0] pin_s3;
    reg  [2:0] pin_filt;
    assign pin_in = {i_accel_address_select_pin, i_sda, i_scl};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_sync
            reg s1;
            reg s2;
            reg s3;
            always @(posedge i_clk_sys or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                end
                else
                begin
                    s1 <= pin_in[g];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign pin_s2[g] = s2;
            assign pin_s3[g] = s3;
        end
    endgenerate

    // a level counts once stages two and three agree
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pin_filt <= 3'h7;
        else
            pin_filt <= (pin_s2 & pin_s3) | (pin_filt & (pin_s2 ^ pin_s3));
    end

    reg  scl_q;
    reg  sda_q;
    wire scl = pin_filt[0];
    wire sda = pin_filt[1];
    wire sel_pin = pin_filt[2];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_ev = scl & scl_q & sda_q & ~sda;
    wire stop_ev  = scl & scl_q & ~sda_q & sda;
    wire [6:0] acc_slave = `CSIR_ACC_SLAVE_ADDR | {6'h00, sel_pin};

    // registers
    reg [7:0] acc_ctrl_one;
    reg [7:0] acc_ctrl_four;
    reg [7:0] mag_cfg_a;
    reg [7:0] mag_cfg_b;
    reg [7:0] mag_mode;
    reg [7:0] acc_ptr;
    reg [7:0] mag_ptr;
    reg [15:0] acc_x;
    reg [15:0] acc_y;
    reg [15:0] acc_z;
    reg [15:0] mag_x;
    reg [15:0] mag_y;
    reg [15:0] mag_z;

    assign o_accel_normal_mode    = |acc_ctrl_one[`CSIR_ACC_POWER_HI:`CSIR_ACC_POWER_LO];
    assign o_accel_big_endian     = acc_ctrl_four[`CSIR_ACC_ENDIAN_BIT];
    assign o_mag_output_data_rate = mag_cfg_a[`CSIR_MAG_RATE_HI:`CSIR_MAG_RATE_LO];
    assign o_mag_continuous       = mag_mode[`CSIR_MAG_MODE_HI:`CSIR_MAG_MODE_LO] == `CSIR_MAG_MODE_CONT;

    // bus engine state
    reg [2:0] state;
    reg [3:0] cnt;
    reg [7:0] shreg;
    reg [7:0] txd;
    reg       drive;
    reg       sel_mag;
    reg       rw;
    reg       first;

    assign o_sda_out  = 1'b0;
    assign o_sda_oe_n = ~drive;

    // read mux for the selected slave
    reg [7:0] rd_addr;
    reg [7:0] rd_data;
    always @*
    begin
        rd_addr = sel_mag ? mag_ptr : acc_ptr;
        rd_data = 8'h00;
        if (sel_mag)
        begin
            if (rd_addr == `CSIR_MAG_CONFIG_A)
                rd_data = mag_cfg_a;
            else if (rd_addr == `CSIR_MAG_CONFIG_B)
                rd_data = mag_cfg_b;
            else if (rd_addr == `CSIR_MAG_OPER_MODE)
                rd_data = mag_mode;
            else if (rd_addr == `CSIR_MAG_X_HIGH)
                rd_data = mag_x[15:8];
            else if (rd_addr == `CSIR_MAG_X_LOW)
                rd_data = mag_x[7:0];
            else if (rd_addr == `CSIR_MAG_Y_HIGH)
                rd_data = mag_y[15:8];
            else if (rd_addr == `CSIR_MAG_Y_LOW)
                rd_data = mag_y[7:0];
            else if (rd_addr == `CSIR_MAG_Z_HIGH)
                rd_data = mag_z[15:8];
            else if (rd_addr == `CSIR_MAG_Z_LOW)
                rd_data = mag_z[7:0];
        end
        else
        begin
            if (rd_addr == `CSIR_ACC_CTRL_ONE)
                rd_data = acc_ctrl_one;
            else if (rd_addr == `CSIR_ACC_CTRL_FOUR)
                rd_data = acc_ctrl_four;
            else if (rd_addr == `CSIR_ACC_X_LOWER)
                rd_data = o_accel_big_endian ? acc_x[15:8] : acc_x[7:0];
            else if (rd_addr == `CSIR_ACC_X_UPPER)
                rd_data = o_accel_big_endian ? acc_x[7:0] : acc_x[15:8];
            else if (rd_addr == `CSIR_ACC_Y_LOWER)
                rd_data = o_accel_big_endian ? acc_y[15:8] : acc_y[7:0];
            else if (rd_addr == `CSIR_ACC_Y_UPPER)
                rd_data = o_accel_big_endian ? acc_y[7:0] : acc_y[15:8];
            else if (rd_addr == `CSIR_ACC_Z_LOWER)
                rd_data = o_accel_big_endian ? acc_z[15:8] : acc_z[7:0];
            else if (rd_addr == `CSIR_ACC_Z_UPPER)
                rd_data = o_accel_big_endian ? acc_z[7:0] : acc_z[15:8];
        end
    end

    // two-entry sample buffer
    reg [BUF_WIDTH-1:0] buf_mem [0:BUF_DEPTH-1];
    reg [BUF_AW-1:0]    buf_wp;
    reg [BUF_AW-1:0]    buf_rp;
    reg [BUF_AW:0]      buf_cnt;
    wire buf_full  = buf_cnt == BUF_DEPTH[BUF_AW:0];
    wire buf_empty = buf_cnt == {(BUF_AW+1){1'b0}};
    wire buf_push  = i_sample_valid & ~buf_full;
    // drain only while the slave engine is idle, so a burst sees one consistent sample
    wire buf_pop   = ~buf_empty & (state == ST_IDLE);
    wire [BUF_WIDTH-1:0] buf_head = buf_mem[buf_rp];
    assign o_sample_ready = ~buf_full;

    always @(posedge i_clk_sys)
    begin
        if (buf_push)
            buf_mem[buf_wp] <= {i_acc_x, i_acc_y, i_acc_z, i_mag_x, i_mag_y, i_mag_z};
    end

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            buf_wp  <= {BUF_AW{1'b0}};
            buf_rp  <= {BUF_AW{1'b0}};
            buf_cnt <= {(BUF_AW+1){1'b0}};
            acc_x   <= 16'h0000;
            acc_y   <= 16'h0000;
            acc_z   <= 16'h0000;
            mag_x   <= 16'h0000;
            mag_y   <= 16'h0000;
            mag_z   <= 16'h0000;
        end
        else
        begin
            if (buf_push)
                buf_wp <= buf_wp + {{(BUF_AW-1){1'b0}}, 1'b1};
            if (buf_pop)
            begin
                buf_rp <= buf_rp + {{(BUF_AW-1){1'b0}}, 1'b1};
                if (o_accel_normal_mode)
                begin
                    acc_x <= buf_head[95:80];
                    acc_y <= buf_head[79:64];
                    acc_z <= buf_head[63:48];
                end
                if (o_mag_continuous)
                begin
                    mag_x <= buf_head[47:32];
                    mag_y <= buf_head[31:16];
                    mag_z <= buf_head[15:0];
                end
            end
            if (buf_push & ~buf_pop)
                buf_cnt <= buf_cnt + {{BUF_AW{1'b0}}, 1'b1};
            else if (buf_pop & ~buf_push)
                buf_cnt <= buf_cnt - {{BUF_AW{1'b0}}, 1'b1};
        end
    end

    // serial slave engine
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_q         <= 1'b1;
            sda_q         <= 1'b1;
            state         <= ST_IDLE;
            cnt           <= 4'h0;
            shreg         <= 8'h00;
            txd           <= 8'h00;
            drive         <= 1'b0;
            sel_mag       <= 1'b0;
            rw            <= 1'b0;
            first         <= 1'b0;
            acc_ptr       <= 8'h00;
            mag_ptr       <= 8'h00;
            acc_ctrl_one  <= `CSIR_ACC_CTRL_ONE_RST;
            acc_ctrl_four <= `CSIR_ACC_CTRL_FOUR_RST;
            mag_cfg_a     <= `CSIR_MAG_CONFIG_A_RST;
            mag_cfg_b     <= `CSIR_MAG_CONFIG_B_RST;
            mag_mode      <= `CSIR_MAG_OPER_MODE_RST;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev)
            begin
                state <= ST_ADDR;
                cnt   <= 4'h0;
                drive <= 1'b0;
            end
            else if (stop_ev)
            begin
                state <= ST_IDLE;
                drive <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (state == ST_ADDR || state == ST_RXB)
                begin
                    shreg <= {shreg[6:0], sda};
                    cnt   <= cnt + 4'h1;
                end
                else if (state == ST_MACK && sda)
                    state <= ST_IDLE;
            end
            else if (scl_fall)
            begin
                case (state)
                    ST_ADDR:
                    begin
                        if (cnt == 4'h8)
                        begin
                            if (shreg[7:1] == acc_slave || shreg[7:1] == `CSIR_MAG_SLAVE_ADDR)
                            begin
                                drive   <= 1'b1;
                                state   <= ST_AACK;
                                sel_mag <= shreg[7:1] == `CSIR_MAG_SLAVE_ADDR;
                                rw      <= shreg[0];
                            end
                            else
                                state <= ST_IDLE;
                        end
                    end
                    ST_AACK:
                    begin
                        if (rw)
                        begin
                            txd   <= rd_data;
                            drive <= ~rd_data[7];
                            cnt   <= 4'h1;
                            state <= ST_TXB;
                            if (sel_mag)
                                mag_ptr <= mag_ptr + 8'h01;
                            else
                                acc_ptr <= acc_ptr + 8'h01;
                        end
                        else
                        begin
                            drive <= 1'b0;
                            cnt   <= 4'h0;
                            first <= 1'b1;
                            state <= ST_RXB;
                        end
                    end
                    ST_RXB:
                    begin
                        if (cnt == 4'h8)
                        begin
                            drive <= 1'b1;
                            state <= ST_RACK;
                            first <= 1'b0;
                            if (first)
                            begin
                                if (sel_mag)
                                    mag_ptr <= shreg;
                                else
                                    acc_ptr <= shreg;
                            end
                            else if (sel_mag)
                            begin
                                if (mag_ptr == `CSIR_MAG_CONFIG_A)
                                    mag_cfg_a <= shreg;
                                else if (mag_ptr == `CSIR_MAG_CONFIG_B)
                                    mag_cfg_b <= shreg;
                                else if (mag_ptr == `CSIR_MAG_OPER_MODE)
                                    mag_mode <= shreg;
                                mag_ptr <= mag_ptr + 8'h01;
                            end
                            else
                            begin
                                if (acc_ptr == `CSIR_ACC_CTRL_ONE)
                                    acc_ctrl_one <= shreg;
                                else if (acc_ptr == `CSIR_ACC_CTRL_FOUR)
                                    acc_ctrl_four <= shreg;
                                acc_ptr <= acc_ptr + 8'h01;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        drive <= 1'b0;
                        cnt   <= 4'h0;
                        state <= ST_RXB;
                    end
                    ST_TXB:
                    begin
                        if (cnt == 4'h8)
                        begin
                            drive <= 1'b0;
                            state <= ST_MACK;
                        end
                        else
                        begin
                            txd   <= {txd[6:0], 1'b0};
                            drive <= ~txd[6];
                            cnt   <= cnt + 4'h1;
                        end
                    end
                    ST_MACK:
                    begin
                        txd   <= rd_data;
                        drive <= ~rd_data[7];
                        cnt   <= 4'h1;
                        state <= ST_TXB;
                        if (sel_mag)
                            mag_ptr <= mag_ptr + 8'h01;
                        else
                            acc_ptr <= acc_ptr + 8'h01;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ===== dv/csir_assertions.sv
`timescale 1ns/1ns
module csir_assertions
(
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic       i_scl,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe_n,
    input wire logic       i_sample_valid,
    input wire logic       o_sample_ready,
    input wire logic       o_accel_normal_mode,
    input wire logic       o_accel_big_endian,
    input wire logic [2:0] o_mag_output_data_rate,
    input wire logic       o_mag_continuous
);
    logic       scl_prev;
    logic [7:0] scl_quiet;

    // cycles since the serial clock last moved
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_prev  <= 1'b1;
            scl_quiet <= 8'hFF;
        end
        else
        begin
            scl_prev  <= i_scl;
            scl_quiet <= (i_scl != scl_prev) ? 8'h00 : ((scl_quiet == 8'hFF) ? scl_quiet : scl_quiet + 8'h01);
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence bus_busy_s;
        scl_quiet < 8'h10;
    endsequence

    sequence push_s;
        i_sample_valid && o_sample_ready;
    endsequence

    reset_config_a: assert property ($rose(i_rst_n) |-> o_mag_output_data_rate == 3'h4 && !o_mag_continuous)
        else $error("config outputs wrong after reset");
    reset_idle_a: assert property ($rose(i_rst_n) |-> o_sda_oe_n && o_sample_ready && !o_accel_normal_mode)
        else $error("bus or buffer not idle after reset");
    normal_by_bus_a: assert property ($changed(o_accel_normal_mode) |-> bus_busy_s)
        else $error("accel mode changed without bus traffic");
    endian_by_bus_a: assert property ($changed(o_accel_big_endian) |-> bus_busy_s)
        else $error("byte order changed without bus traffic");
    rate_by_bus_a: assert property ($changed(o_mag_output_data_rate) |-> bus_busy_s)
        else $error("mag rate changed without bus traffic");
    mode_by_bus_a: assert property ($changed(o_mag_continuous) |-> bus_busy_s)
        else $error("mag mode changed without bus traffic");
    sda_quiet_a: assert property (!o_sda_oe_n |-> bus_busy_s)
        else $error("data line held while bus idle");
    sda_scl_low_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
        else $error("data drive changed with clock high");
    open_drain_a: assert property (o_sda_out == 1'b0)
        else $error("data value not low");
    buffer_full_a: assert property ($fell(o_sample_ready) |-> $past(i_sample_valid) && $past(o_sample_ready))
        else $error("buffer full without a push");
    cover property (push_s ##1 !o_sample_ready);
endmodule

// ===== dv/csir_i2c_master.sv
`timescale 1ns/1ns
module csir_i2c_master
#(
    parameter int HALF = 200
)
(
    input  wire logic       i_clk,
    input  wire logic       i_sda,
    output logic            o_scl,
    output logic            o_sda,
    output logic            o_rd_stb,
    output logic [7:0]      o_rd_byte,
    output logic [15:0]     o_rd_word
);
    initial
    begin
        o_scl     = 1'b1;
        o_sda     = 1'b1;
        o_rd_stb  = 1'b0;
        o_rd_byte = 8'h00;
        o_rd_word = 16'h0000;
    end

    // one clocked bit; long low phase covers the slave's answer lag; 1 releases the line
    task automatic bit_io(input logic b, output logic s);
        o_sda = b;
        #(HALF*3/4);
        o_scl = 1'b1;
        #(HALF/2);
        s = i_sda;
        o_scl = 1'b0;
        #(HALF*3/4);
    endtask

    task automatic start_cond;
        @(posedge i_clk);
        #7;
        o_sda = 1'b1;
        #(HALF/2);
        o_scl = 1'b1;
        #HALF;
        o_sda = 1'b0;
        #HALF;
        o_scl = 1'b0;
        #(HALF/2);
    endtask

    task automatic stop_cond;
        o_sda = 1'b0;
        #(HALF*3/4);
        o_scl = 1'b1;
        #HALF;
        o_sda = 1'b1;
        #HALF;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        int i;
        logic s;
        for (i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask

    task automatic recv_byte(input logic last);
        int i;
        logic s;
        logic [7:0] r;
        for (i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            r[i] = s;
        end
        bit_io(last, s);
        o_rd_byte = r;
        o_rd_word = (o_rd_word << 8) + {8'h00, r};
        #1;
        o_rd_stb  = 1'b1;
        #1;
        o_rd_stb  = 1'b0;
    endtask

    task automatic probe(input logic [6:0] a, output logic ack);
        start_cond;
        send_byte({a, 1'b0}, ack);
        stop_cond;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
        logic k;
        start_cond;
        send_byte({a, 1'b0}, k);
        send_byte(r, k);
        send_byte(d, k);
        stop_cond;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] r, input int n);
        int i;
        logic k;
        start_cond;
        send_byte({a, 1'b0}, k);
        send_byte(r, k);
        start_cond;
        send_byte({a, 1'b1}, k);
        for (i = 0; i < n; i++)
            recv_byte(i == n - 1);
        stop_cond;
    endtask

    // pointer_sequential_read: no register address sent
    task automatic cur(input logic [6:0] a);
        logic k;
        start_cond;
        send_byte({a, 1'b1}, k);
        recv_byte(1'b1);
        stop_cond;
    endtask
endmodule

// ===== dv/compass_sensor_i2c_readout_test.sv
`timescale 1ns/1ns
module compass_sensor_i2c_readout_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pin_sel = 1'b0;
    logic        valid = 1'b0;
    logic [15:0] smp [0:5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] expq [$];
    logic        k;
    int          seed = 13599;
    int          n_fail = 0;
    int          checks = 0;
    int          i;
    wire         scl, sda_m, sda, sda_out, sda_oe_n, ready, normal, big, cont, rd_stb;
    wire [2:0]   rate;
    wire [7:0]   rd_byte;
    wire [15:0]  rd_word;

    assign sda = sda_m & (sda_oe_n | sda_out);

    always #25 clk = ~clk;

    csir_top DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
        .o_sda_oe_n(sda_oe_n), .i_accel_address_select_pin(pin_sel), .i_sample_valid(valid),
        .o_sample_ready(ready), .i_acc_x(smp[0]), .i_acc_y(smp[1]), .i_acc_z(smp[2]), .i_mag_x(smp[3]),
        .i_mag_y(smp[4]), .i_mag_z(smp[5]), .o_accel_normal_mode(normal), .o_accel_big_endian(big),
        .o_mag_output_data_rate(rate), .o_mag_continuous(cont));

    csir_i2c_master mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m), .o_rd_stb(rd_stb),
        .o_rd_byte(rd_byte), .o_rd_word(rd_word));

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic note(input logic [7:0] b);
        expq.push_back({8'h00, b});
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic push(input int n);
        int j;
        int t;
        repeat (n)
        begin
            @(posedge clk);
            valid <= 1'b1;
            for (j = 0; j < 6; j++)
            begin
                t = $random(seed);
                smp[j] <= t[15:0];
            end
        end
        @(posedge clk);
        valid <= 1'b0;
    endtask

    // read results against the oldest note
    always @(posedge rd_stb)
        check({8'h00, rd_byte}, (expq.size() != 0) ? expq.pop_front() : 16'hXXXX);

    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check(normal, 1'b0);
        check(big, 1'b0);
        check(rate, 3'h4);
        check(cont, 1'b0);
        check(ready, 1'b1);
        mst.probe(7'h19, k);
        check(k, 1'b1);
        mst.probe(7'h18, k);
        check(k, 1'b0);
        mst.probe(7'h1E, k);
        check(k, 1'b0);
        @(posedge clk);
        pin_sel <= 1'b1;
        mst.probe(7'h19, k);
        check(k, 1'b0);
        @(posedge clk);
        pin_sel <= 1'b0;
        // host configures before reading
        mst.wr(7'h18, 8'h20, 8'h27);
        check(normal, 1'b1);
        note(8'h27);
        mst.rd(7'h18, 8'h20, 1);
        mst.wr(7'h18, 8'h23, 8'h40);
        check(big, 1'b1);
        check(normal, 1'b1);
        mst.wr(7'h1E, 8'h00, 8'h14);
        check(rate, 3'h5);
        mst.wr(7'h1E, 8'h02, 8'h00);
        check(cont, 1'b1);
        // little-endian pass, then back to big-endian
        mst.wr(7'h18, 8'h23, 8'h00);
        check(big, 1'b0);
        push(1);
        note(smp[0][7:0]);
        note(smp[0][15:8]);
        mst.rd(7'h18, 8'h28, 2);
        mst.wr(7'h18, 8'h23, 8'h40);
        check(big, 1'b1);
        // fill the buffer while a transfer is open
        mst.start_cond;
        mst.send_byte({7'h1E, 1'b0}, k);
        push(2);
        @(negedge clk);
        check(ready, 1'b0);
        mst.stop_cond;
        for (i = 0; i < 50 && ready !== 1'b1; i++)
            @(negedge clk);
        check(ready, 1'b1);
        // host joins high and low into one word
        for (i = 0; i < 3; i++)
        begin
            note(smp[i][15:8]);
            note(smp[i][7:0]);
        end
        mst.rd(7'h18, 8'h28, 6);
        check(rd_word, smp[2]);
        note(8'h00);
        mst.rd(7'h1E, 8'h02, 1);
        for (i = 3; i < 6; i++)
        begin
            note(smp[i][15:8]);
            note(smp[i][7:0]);
        end
        repeat (6) mst.cur(7'h1E);
        check(rd_word, smp[5]);
        mst.wr(7'h1E, 8'h03, ~smp[3][15:8]);
        note(smp[3][15:8]);
        mst.rd(7'h1E, 8'h03, 1);
        note(8'h00);
        mst.rd(7'h18, 8'h10, 1);
        check(16'(expq.size()), 16'h0000);
        tally_and_finish;
    end
endmodule

bind csir_top csir_assertions u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_sample_valid(i_sample_valid),
    .o_sample_ready(o_sample_ready), .o_accel_normal_mode(o_accel_normal_mode),
    .o_accel_big_endian(o_accel_big_endian), .o_mag_output_data_rate(o_mag_output_data_rate),
    .o_mag_continuous(o_mag_continuous));
